// ---- rtl/lbw_bus_if.sv ----
// Parallel host bus between the host controller and the display port
`timescale 1ns/1ps
`default_nettype none
interface lbw_bus_if;
    logic [3:0] host_bus_select_pins;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic register_or_data_select;
    logic [17:0] host_data_out;
    logic host_data_oe_n;
    logic [17:0] dev_data_out;
    logic dev_data_oe_n;
    logic [17:0] parallel_data_lines;

    // Wire level from the enables; undriven lines float high
    assign parallel_data_lines = !host_data_oe_n ? host_data_out :
                                 !dev_data_oe_n ? dev_data_out : 18'h3_ffff;

    modport host (
        output host_bus_select_pins, chip_select_n, write_strobe_n, read_strobe_n,
        output register_or_data_select, host_data_out, host_data_oe_n,
        input parallel_data_lines
    );
    modport dev (
        input host_bus_select_pins, chip_select_n, write_strobe_n, read_strobe_n,
        input register_or_data_select, parallel_data_lines,
        output dev_data_out, dev_data_oe_n
    );
endinterface
`default_nettype wire

// ---- rtl/lbw_dev_port.sv ----
// Display side of the parallel host bus: width select, byte pairing, sync
// Notes on behaviour
// R1 - Straps 1010 select eighteen data lines
// R2 - Straps 0010 select sixteen lines 17:10, 8:1
// R3 - Sixteen-line mode accepts 65K or 262K pixels
// R4 - 262K over sixteen lines: 2+16 bits merged
// R5 - Straps 1011 select nine lines 17:9
// R6 - Straps 0011 select eight lines 17:10
// R7 - Narrow registers go upper byte then lower
// R8 - Nine-line pixels: upper nine bits first
// R9 - Eight-line pixels: upper byte first
// R10 - Eight-line pixels widened to 18 bits
// R11 - Four 00h index writes reset byte counter
// R12 - Width field picks 18, 16, 6 lines; 11 forbidden
// R13 - Index with select low, contents with select high
// R14 - Counter alternates; word commits on lower byte
`timescale 1ns/1ps
`default_nettype none
module lbw_dev_port
    import lbw_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    lbw_bus_if.dev bus,
    input wire logic pixel_262k_in,
    input wire logic pixel_short_first_in,
    input wire logic [1:0] pixel_port_width_field_in,
    input wire logic [15:0] reg_rd_data_in,
    output logic [15:0] index_out,
    output logic reg_wr_valid_out,
    output logic [15:0] reg_wr_data_out,
    output logic pix_valid_out,
    output logic [17:0] pix_data_out,
    output logic [17:0] rgb_lane_mask_out,
    output logic rgb_width_bad_out,
    output logic [2:0] bus_mode_out,
    output logic sync_event_out
);
    localparam int SW = 26;

    logic [SW-1:0] pin_s1_reg;
    logic [SW-1:0] pin_s2_reg;
    logic cs_n_s, wr_n_s, rd_n_s, rs_s;
    logic [3:0] sel_s;
    logic [17:0] db_s;
    logic wr_prev_reg, rd_prev_reg, cs_prev_reg;
    logic take, rd_end;
    lbw_mode_t mode;
    logic narrow;
    logic half_reg;
    logic [2:0] sync_cnt_reg;
    logic sync_hit;
    logic [8:0] upper_reg;
    logic [15:0] short_reg;
    logic [1:0] two_reg;
    logic pix_half_reg;
    logic [15:0] index_reg;
    logic commit;
    logic [15:0] word;
    logic [17:0] pix_word;
    logic pix_done;
    logic [17:0] rd_word;

    // Two-stage synchroniser on every pin
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
        end else begin
            pin_s1_reg <= {bus.chip_select_n, bus.write_strobe_n, bus.read_strobe_n,
                           bus.register_or_data_select, bus.host_bus_select_pins,
                           bus.parallel_data_lines};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign {cs_n_s, wr_n_s, rd_n_s, rs_s, sel_s, db_s} = pin_s2_reg;
    assign mode = decode_mode(sel_s); // R1 R2 R5 R6
    assign narrow = (mode == MODE_9) || (mode == MODE_8);
    assign bus_mode_out = mode;

    // Strobe edge history
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            wr_prev_reg <= wr_n_s;
            rd_prev_reg <= rd_n_s;
            cs_prev_reg <= cs_n_s;
        end
    end

    // A transfer ends on the strobe's rising edge while selected
    assign take = wr_n_s && !wr_prev_reg && !cs_prev_reg && (mode != MODE_OFF);
    assign rd_end = rd_n_s && !rd_prev_reg && !cs_prev_reg && (mode != MODE_OFF);
    assign sync_hit = take && narrow && !rs_s && (db_s[17:10] == SYNC_BYTE)
                      && (sync_cnt_reg == SYNC_COUNT - 3'h1);

    // Count consecutive 00h index bytes
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_cnt_reg <= 3'h0;
        end else if (sync_hit) begin
            sync_cnt_reg <= 3'h0; // R11
        end else if (take && narrow && !rs_s && (db_s[17:10] == SYNC_BYTE)) begin
            sync_cnt_reg <= sync_cnt_reg + 3'h1; // R11
        end else if (take || rd_end) begin
            sync_cnt_reg <= 3'h0;
        end
    end

    // Upper/lower byte counter
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            half_reg <= 1'b0;
        end else if (!narrow || sync_hit) begin
            half_reg <= 1'b0; // R11
        end else if (take || rd_end) begin
            half_reg <= !half_reg; // R14
        end
    end

    // Hold the upper part until its partner arrives
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            upper_reg <= 9'h000;
        end else if (take && narrow && !half_reg) begin
            upper_reg <= db_s[17:9]; // R7 R8 R9
        end
    end

    assign commit = take && (!narrow || (half_reg && !sync_hit)); // R14

    // Assemble register word and pixel from the active lanes
    always_comb begin
        word = from_lanes16(db_s);
        pix_word = db_s;
        if (mode == MODE_16) begin
            pix_word = widen565(from_lanes16(db_s));
        end else if (narrow) begin
            word = {upper_reg[8:1], db_s[17:10]}; // R7
            if (mode == MODE_9) begin
                pix_word = {upper_reg, db_s[17:9]}; // R8
            end else begin
                pix_word = widen565({upper_reg[8:1], db_s[17:10]}); // R9 R10
            end
        end
    end

    // Pairing of the 2-bit and 16-bit parts of a 262K pixel
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pix_half_reg <= 1'b0;
            short_reg <= 16'h0000;
            two_reg <= 2'h0;
        end else if (mode != MODE_16 || !pixel_262k_in || !rs_s) begin
            pix_half_reg <= 1'b0;
        end else if (commit && index_reg == GRAPHICS_MEMORY_INDEX) begin
            pix_half_reg <= !pix_half_reg; // R4
            if (!pix_half_reg) begin
                short_reg <= from_lanes16(db_s);
                two_reg <= db_s[2:1];
            end
        end
    end

    assign pix_done = (mode != MODE_16) || !pixel_262k_in || pix_half_reg; // R3

    // Index with select low, contents with select high
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            index_reg <= 16'h0000;
        end else if (commit && !rs_s) begin
            index_reg <= word; // R13
        end
    end
    assign index_out = index_reg;

    // Register write and pixel delivery, one-cycle valids
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_wr_valid_out <= 1'b0;
            reg_wr_data_out <= 16'h0000;
            pix_valid_out <= 1'b0;
            pix_data_out <= 18'h0_0000;
        end else begin
            reg_wr_valid_out <= commit && rs_s && index_reg != GRAPHICS_MEMORY_INDEX; // R13
            pix_valid_out <= commit && rs_s && index_reg == GRAPHICS_MEMORY_INDEX && pix_done;
            if (commit && rs_s) begin
                reg_wr_data_out <= word;
            end
            if (commit && rs_s && index_reg == GRAPHICS_MEMORY_INDEX) begin
                if (mode == MODE_16 && pixel_262k_in) begin
                    if (pixel_short_first_in) begin
                        pix_data_out <= {two_reg, from_lanes16(db_s)}; // R4
                    end else begin
                        pix_data_out <= {db_s[2:1], short_reg}; // R4
                    end
                end else begin
                    pix_data_out <= pix_word;
                end
            end
        end
    end

    // Sync event pulse for the user side
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_event_out <= 1'b0;
        end else begin
            sync_event_out <= sync_hit;
        end
    end

    // Read data on the active lanes, upper byte first when narrow
    always_comb begin
        rd_word = lanes16(reg_rd_data_in);
        if (narrow) begin
            rd_word = half_reg ? {reg_rd_data_in[7:0], 10'h000} // R7
                               : {reg_rd_data_in[15:8], 10'h000};
        end
    end

    // Drive the lines only while a selected read strobe is low
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus.dev_data_out <= 18'h0_0000;
            bus.dev_data_oe_n <= 1'b1;
        end else begin
            bus.dev_data_out <= rd_word;
            bus.dev_data_oe_n <= !(!cs_n_s && !rd_n_s && rs_s && mode != MODE_OFF);
        end
    end

    // Pixel port width selection
    always_comb begin
        rgb_width_bad_out = 1'b0;
        unique case (pixel_port_width_field_in)
            PIX_W_18: rgb_lane_mask_out = MASK_18; // R12
            PIX_W_16: rgb_lane_mask_out = MASK_16; // R12
            PIX_W_6: rgb_lane_mask_out = MASK_6; // R12
            default: begin
                rgb_lane_mask_out = 18'h0_0000; // R12
                rgb_width_bad_out = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- rtl/lbw_host_ctrl.sv ----
// Host side of the parallel bus: splits commands into strobed transfers
`timescale 1ns/1ps
`default_nettype none
module lbw_host_ctrl
    import lbw_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    lbw_bus_if.host bus,
    input wire logic [3:0] bus_select_in,
    input wire logic pixel_262k_in,
    input wire logic pixel_short_first_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire lbw_cmd_t cmd_kind_in,
    input wire logic [17:0] cmd_data_in,
    output logic rd_valid_out,
    output logic [15:0] rd_data_out
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_LOW = 4'h4,
        ST_HIGH = 4'h8
    } lbw_hst_t;

    lbw_hst_t state_reg;
    logic [17:0] part_reg [0:3];
    logic [17:0] part_next [0:3];
    logic [2:0] nparts_reg, nparts_next;
    logic [2:0] idx_reg;
    logic rs_reg, read_reg, rs_next;
    logic [5:0] timer_reg;
    logic [17:0] db_s1_reg, db_s2_reg;
    logic [15:0] rd_acc_reg;
    lbw_mode_t mode;
    logic narrow;
    logic [15:0] d16;

    assign mode = decode_mode(bus_select_in);
    assign narrow = (mode == MODE_9) || (mode == MODE_8);
    assign d16 = cmd_data_in[15:0];
    assign bus.host_bus_select_pins = bus_select_in; // R1 R2 R5 R6
    assign cmd_ready_out = (state_reg == ST_IDLE) && (mode != MODE_OFF);

    // Split one command into its lane transfers
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            part_next[i] = 18'h0_0000;
        end
        nparts_next = 3'h1;
        rs_next = (cmd_kind_in != CMD_INDEX) && (cmd_kind_in != CMD_SYNC); // R13
        part_next[0] = lanes16(d16);
        if (narrow) begin
            nparts_next = 3'h2;
            part_next[0] = {d16[15:8], 10'h000}; // R7
            part_next[1] = {d16[7:0], 10'h000};
        end
        if (cmd_kind_in == CMD_SYNC) begin
            nparts_next = SYNC_COUNT; // R11
            part_next[0] = {SYNC_BYTE, 10'h000};
            part_next[1] = {SYNC_BYTE, 10'h000};
            part_next[2] = {SYNC_BYTE, 10'h000};
            part_next[3] = {SYNC_BYTE, 10'h000};
        end else if (cmd_kind_in == CMD_PIXEL) begin
            unique case (mode)
                MODE_18: part_next[0] = cmd_data_in; // R1
                MODE_16: begin
                    if (pixel_262k_in) begin
                        nparts_next = 3'h2; // R4
                        part_next[0] = pixel_short_first_in ? {15'h0000, cmd_data_in[17:16], 1'b0}
                                                          : lanes16(cmd_data_in[15:0]);
                        part_next[1] = pixel_short_first_in ? lanes16(cmd_data_in[15:0])
                                                          : {15'h0000, cmd_data_in[17:16], 1'b0};
                    end else begin
                        part_next[0] = lanes16({cmd_data_in[17:13], cmd_data_in[11:6],
                                                cmd_data_in[5:1]}); // R3
                    end
                end
                MODE_9: begin
                    part_next[0] = {cmd_data_in[17:9], 9'h000}; // R8
                    part_next[1] = {cmd_data_in[8:0], 9'h000};
                end
                default: begin
                    part_next[0] = {cmd_data_in[17:13], cmd_data_in[11:9], 10'h000}; // R9
                    part_next[1] = {cmd_data_in[8:6], cmd_data_in[5:1], 10'h000};
                end
            endcase
        end
    end

    // Transfer sequencer
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            timer_reg <= 6'h00;
            idx_reg <= 3'h0;
            nparts_reg <= 3'h1;
            rs_reg <= 1'b0;
            read_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                part_reg[i] <= 18'h0_0000;
            end
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        for (int i = 0; i < 4; i++) begin
                            part_reg[i] <= part_next[i];
                        end
                        nparts_reg <= nparts_next;
                        rs_reg <= rs_next;
                        read_reg <= (cmd_kind_in == CMD_REG_RD);
                        idx_reg <= 3'h0;
                        timer_reg <= 6'(SETUP_CYC);
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    timer_reg <= timer_reg - 6'h01;
                    if (timer_reg == 6'h01) begin
                        timer_reg <= read_reg ? 6'(RD_LOW_CYC) : 6'(WR_LOW_CYC);
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    timer_reg <= timer_reg - 6'h01;
                    if (timer_reg == 6'h01) begin
                        timer_reg <= read_reg ? 6'(RD_HIGH_CYC) : 6'(WR_HIGH_CYC);
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    timer_reg <= timer_reg - 6'h01;
                    if (timer_reg == 6'h01) begin
                        idx_reg <= idx_reg + 3'h1;
                        timer_reg <= read_reg ? 6'(RD_LOW_CYC) : 6'(WR_LOW_CYC);
                        state_reg <= (idx_reg + 3'h1 == nparts_reg) ? ST_IDLE : ST_LOW;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Bus pins follow the sequencer state
    assign bus.chip_select_n = (state_reg == ST_IDLE);
    assign bus.register_or_data_select = rs_reg; // R13
    assign bus.write_strobe_n = !((state_reg == ST_LOW) && !read_reg);
    assign bus.read_strobe_n = !((state_reg == ST_LOW) && read_reg);
    assign bus.host_data_oe_n = (state_reg == ST_IDLE) || read_reg;
    assign bus.host_data_out = part_reg[idx_reg[1:0]];

    // Returned data lines through two flip-flops
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            db_s1_reg <= 18'h0_0000;
            db_s2_reg <= 18'h0_0000;
        end else begin
            db_s1_reg <= bus.parallel_data_lines;
            db_s2_reg <= db_s1_reg;
        end
    end

    // Sample read data at the end of each low phase
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_acc_reg <= 16'h0000;
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= 1'b0;
            if (state_reg == ST_LOW && read_reg && timer_reg == 6'h01) begin
                if (!narrow) begin
                    rd_data_out <= from_lanes16(db_s2_reg);
                    rd_valid_out <= 1'b1;
                end else if (idx_reg == 3'h0) begin
                    rd_acc_reg <= {db_s2_reg[17:10], 8'h00}; // R7
                end else begin
                    rd_data_out <= {rd_acc_reg[15:8], db_s2_reg[17:10]};
                    rd_valid_out <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lbw_pkg.sv ----
// Shared constants, types and lane helpers for the host bus width adapter
package lbw_pkg;
    localparam int DB_W = 18;
    // Static bus select strap codes
    localparam logic [3:0] SEL_18 = 4'ha;
    localparam logic [3:0] SEL_16 = 4'h2;
    localparam logic [3:0] SEL_9 = 4'hb;
    localparam logic [3:0] SEL_8 = 4'h3;
    // Pixel port width field codes and the lines each one uses
    localparam logic [1:0] PIX_W_18 = 2'h0;
    localparam logic [1:0] PIX_W_16 = 2'h1;
    localparam logic [1:0] PIX_W_6 = 2'h2;
    localparam logic [17:0] MASK_18 = 18'h3_ffff;
    localparam logic [17:0] MASK_16 = 18'h3_effe;
    localparam logic [17:0] MASK_6 = 18'h3_f000;
    // Index of the graphics memory write port and the sync pattern
    localparam logic [15:0] GRAPHICS_MEMORY_INDEX = 16'h0022;
    localparam logic [7:0] SYNC_BYTE = 8'h00;
    localparam logic [2:0] SYNC_COUNT = 3'h4;
    // Strobe timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SETUP_NS = 10;
    localparam int WR_LOW_NS = 50;
    localparam int WR_HIGH_NS = 50;
    localparam int RD_LOW_NS = 150;
    localparam int RD_HIGH_NS = 150;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_LOW_CYC = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_HIGH_CYC = (WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LOW_CYC = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_HIGH_CYC = (RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_18 = 3'h0,
        MODE_16 = 3'h1,
        MODE_9 = 3'h2,
        MODE_8 = 3'h3,
        MODE_OFF = 3'h4
    } lbw_mode_t;

    typedef enum logic [2:0] {
        CMD_INDEX = 3'h0,
        CMD_REG_WR = 3'h1,
        CMD_REG_RD = 3'h2,
        CMD_PIXEL = 3'h3,
        CMD_SYNC = 3'h4
    } lbw_cmd_t;

    // Strap decode; unknown codes leave the port idle
    function automatic lbw_mode_t decode_mode(input logic [3:0] sel);
        decode_mode = MODE_OFF;
        if (sel == SEL_18) decode_mode = MODE_18;
        if (sel == SEL_16) decode_mode = MODE_16;
        if (sel == SEL_9) decode_mode = MODE_9;
        if (sel == SEL_8) decode_mode = MODE_8;
    endfunction

    // 16-bit word onto lines 17..10 and 8..1
    function automatic logic [17:0] lanes16(input logic [15:0] d);
        lanes16 = {d[15:8], 1'b0, d[7:0], 1'b0};
    endfunction

    function automatic logic [15:0] from_lanes16(input logic [17:0] db);
        from_lanes16 = {db[17:10], db[8:1]};
    endfunction

    // 5-6-5 colour widened to 6-6-6
    function automatic logic [17:0] widen565(input logic [15:0] d);
        widen565 = {d[15:11], d[15], d[10:5], d[4:0], d[4]};
    endfunction
endpackage

// ---- verif/lbw_asserts.sv ----
// Bus protocol checks on the parallel host bus
`timescale 1ns/1ps
`default_nettype none
module lbw_asserts (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic register_or_data_select,
    input wire logic [17:0] host_data_out,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n,
    input wire logic [17:0] parallel_data_lines
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Write strobe phases
    sequence s_wr_start;
        $fell(write_strobe_n);
    endsequence
    sequence s_wr_hold;
        (!write_strobe_n && !chip_select_n)[*8];
    endsequence
    property p_wr_low;
        s_wr_start |-> s_wr_hold;
    endproperty
    property p_setup;
        $fell(chip_select_n) |-> (write_strobe_n && read_strobe_n)[*3];
    endproperty
    property p_excl;
        !(!write_strobe_n && !read_strobe_n);
    endproperty
    property p_host_drive;
        !write_strobe_n |-> !host_data_oe_n && dev_data_oe_n;
    endproperty
    property p_stable;
        !write_strobe_n && !$past(write_strobe_n) |->
            $stable(host_data_out) && $stable(register_or_data_select);
    endproperty
    property p_rd_answer;
        $fell(read_strobe_n) |-> ##[2:6] !dev_data_oe_n;
    endproperty
    property p_rd_release;
        $rose(read_strobe_n) |-> ##[1:6] dev_data_oe_n;
    endproperty
    // Host and display never drive the lines together
    property p_wire;
        !(!host_data_oe_n && !dev_data_oe_n);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("write strobe low too short");
    a_setup: assert property (p_setup) else $error("strobe before setup");
    a_excl: assert property (p_excl) else $error("both strobes low");
    a_host_drive: assert property (p_host_drive) else $error("lines not host driven");
    a_stable: assert property (p_stable) else $error("data moved in strobe");
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    a_rd_release: assert property (p_rd_release) else $error("read lines held");
    a_wire: assert property (p_wire) else $error("bus contention");
endmodule
`default_nettype wire

// ---- verif/lcd_host_bus_width_adapter_test.sv ----
// Self-checking bench: host controller talking to display port
`timescale 1ns/1ps
`default_nettype none
module lcd_host_bus_width_adapter_test
    import lbw_pkg::*;
;
    logic ref_clk_in, rst_n_in, p262, sfirst, cvalid, cready, rvalid;
    logic wvalid, pvalid, bad, sev;
    logic [3:0] straps;
    logic [1:0] wfield;
    logic [15:0] rsrc, rdata, idxq, wdata, idx;
    logic [17:0] cdata, pdata, mask, lwr, lpix, lrd, d;
    logic [2:0] mode;
    logic [31:0] seed;
    lbw_cmd_t ckind;
    int bad_count, n_tests, nw, np, ns, nr;
    lbw_bus_if bus_i();
    lbw_host_ctrl u_lbw_host_ctrl(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_i),
        .bus_select_in(straps), .pixel_262k_in(p262), .pixel_short_first_in(sfirst),
        .cmd_valid_in(cvalid), .cmd_ready_out(cready), .cmd_kind_in(ckind),
        .cmd_data_in(cdata), .rd_valid_out(rvalid), .rd_data_out(rdata));
    lbw_dev_port u_lbw_dev_port(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus(bus_i),
        .pixel_262k_in(p262), .pixel_short_first_in(sfirst), .pixel_port_width_field_in(wfield),
        .reg_rd_data_in(rsrc), .index_out(idxq), .reg_wr_valid_out(wvalid),
        .reg_wr_data_out(wdata), .pix_valid_out(pvalid), .pix_data_out(pdata),
        .rgb_lane_mask_out(mask), .rgb_width_bad_out(bad), .bus_mode_out(mode),
        .sync_event_out(sev));
    lbw_asserts u_lbw_asserts(.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .chip_select_n(bus_i.chip_select_n), .write_strobe_n(bus_i.write_strobe_n),
        .read_strobe_n(bus_i.read_strobe_n),
        .register_or_data_select(bus_i.register_or_data_select),
        .host_data_out(bus_i.host_data_out), .host_data_oe_n(bus_i.host_data_oe_n),
        .dev_data_oe_n(bus_i.dev_data_oe_n), .parallel_data_lines(bus_i.parallel_data_lines));
    // Clock, 4 ns period
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // Capture of device pulses and host read returns
    always @(posedge ref_clk_in) begin
        if (wvalid === 1'b1) begin nw++; lwr = {2'h0, wdata}; end
        if (pvalid === 1'b1) begin np++; lpix = pdata; end
        if (rvalid === 1'b1) begin nr++; lrd = {2'h0, rdata}; end
        if (sev === 1'b1) ns++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // 5-6-5 modes keep the top bits of each colour, widened by MSB repeat
    function automatic logic [17:0] exp_pix(input int m, input logic [17:0] v);
        exp_pix = (m == 3 || m == 5) ? {v[17:13], v[17], v[11:6], v[5:1], v[5]} : v;
    endfunction
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset(input logic [3:0] s);
        rst_n_in = 1'b0;
        straps = s;
        repeat (6) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
    endtask
    // Hold the request until ready is seen at an edge
    task automatic send(input lbw_cmd_t k, input logic [17:0] v);
        @(posedge ref_clk_in);
        #1 cvalid = 1'b1;
        ckind = k;
        cdata = v;
        for (int i = 0; i < 500; i++) begin
            @(negedge ref_clk_in);
            if (cready === 1'b1) break;
        end
        @(posedge ref_clk_in);
        #1 cvalid = 1'b0;
        for (int i = 0; i < 500; i++) begin
            @(negedge ref_clk_in);
            if (cready === 1'b1) break;
        end
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_in);
        bad_count++;
        give_verdict();
    end
    initial begin
        {p262, sfirst, cvalid, wfield, rsrc, cdata} = '0;
        ckind = CMD_INDEX;
        seed = 32'he5b92fde;
        do_reset(4'h0);
        chk(18'(mode), 18'h0_0004);
        chk(18'(cready), 18'h0_0000);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_in);
            #1 wfield = 2'(i);
            #1 chk(mask, i == 0 ? MASK_18 : i == 1 ? MASK_16 : i == 2 ? MASK_6 : 18'h0);
            chk(18'(bad), 18'(i == 3));
        end
        for (int m = 0; m < 6; m++) begin
            p262 = (m == 1 || m == 2);
            sfirst = (m == 1);
            do_reset(m == 0 ? SEL_18 : m < 4 ? SEL_16 : m == 4 ? SEL_9 : SEL_8);
            chk(18'(mode), m == 0 ? 18'h0 : m < 4 ? 18'h1 : m == 4 ? 18'h2 : 18'h3);
            seed = lfsr(seed);
            idx = {8'h00, seed[7:0] | 8'h40};
            send(CMD_INDEX, 18'(idx));
            chk(18'(idxq), 18'(idx));
            send(CMD_REG_WR, 18'(seed[31:16]));
            chk(lwr, 18'(seed[31:16]));
            rsrc = seed[23:8];
            send(CMD_REG_RD, 18'h0);
            chk(lrd, 18'(rsrc));
            send(CMD_INDEX, 18'(GRAPHICS_MEMORY_INDEX));
            for (int k = 0; k < 3; k++) begin
                seed = lfsr(seed);
                d = k == 0 ? 18'h3_ffff : seed[17:0];
                send(CMD_PIXEL, d);
                chk(lpix, exp_pix(m, d));
            end
            chk(18'(np), 18'(3 * m + 3));
            if (m > 3) begin
                send(CMD_SYNC, 18'h0);
                chk(18'(ns), 18'(m - 3));
                send(CMD_INDEX, 18'(idx));
                chk(18'(idxq), 18'(idx));
            end
            $display("mode step %0d done", m);
        end
        chk(18'(nw), 18'h0_0006);
        chk(18'(nr), 18'h0_0006);
        give_verdict();
    end
endmodule
`default_nettype wire
